// ===== hw/rtcam_top.v
// Dual alarm compare block with status, control and shared pin logic.
`timescale 1ns/1ns
`include "rtcam_defines.vh"
module rtcam_top (
  // Clock and reset.
  input  wire       clk,
  input  wire       rst,
  // Register port from the serial slave.
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire       sr_read_stop,
  output reg  [7:0] reg_rdata_r,
  // Time base from the timekeeping counters.
  input  wire       sec_tick,
  input  wire [7:0] time_sec,
  input  wire [7:0] time_min,
  input  wire [7:0] time_hour,
  input  wire [7:0] time_date,
  input  wire [7:0] time_month,
  input  wire [7:0] weekday_count,
  // Shared interrupt and frequency pin.
  output reg        irq_pin_o_r,
  output reg        irq_pin_oe_n_r,
  output reg        fout_en_r,
  output reg  [1:0] fout_sel_r,
  // Alarm state.
  output wire       first_alarm_flag,
  output wire       second_alarm_flag,
  output reg        first_alarm_event_r,
  output reg        second_alarm_event_r
);

  // Alarm 1 bytes.
  reg  [7:0] alarm1_second_r;
  reg  [7:0] alarm1_minute_r;
  reg  [7:0] alarm1_hour_r;
  reg  [7:0] alarm1_date_r;
  reg  [7:0] alarm1_month_r;
  reg  [7:0] alarm1_weekday_r;
  // Alarm 2 bytes.
  reg  [7:0] alarm2_minute_r;
  reg  [7:0] alarm2_hour_r;
  reg  [7:0] alarm2_day_or_date_r;
  // Control bits.
  reg        flag_autoclear_on_read_r;
  reg        first_alarm_global_on_r;
  reg        second_alarm_global_on_r;
  reg        pin_irq_select_r;
  reg        first_alarm_pin_route_r;
  reg  [1:0] fo_sel_r;
  // Match terms.
  wire [5:0] a1_hit;
  wire [2:0] a2_hit;
  wire       a1_match;
  wire       a2_match;
  wire       a1_set;
  wire       a2_set;
  wire       at_minute;
  // Clear terms.
  wire       wr_status;
  wire       autoclear;
  wire       clr1;
  wire       clr2;
  // Pin terms and the next read data.
  wire       pin_irq_mode;
  wire       pin_freq_mode;
  reg  [7:0] rdata_nxt;

  // A field hits when disabled or when the value bits agree.
  // The hour value bits include the 12/24 select, so a format
  // mismatch can never hit an enabled hour field.
  // The enable bit itself is never part of the value compare.
  function field_hit;
    input [7:0] alm;
    input [7:0] tim;
    begin
      field_hit = !alm[`RTCAM_ALM_EN] || (alm[6:0] == tim[6:0]);
    end
  endfunction

  // The day-or-date byte compares either weekday or date.
  // Bit 6 is the selector itself, so only bits 5 to 0 carry the
  // value; both the weekday and the date fit in that width.
  function daydate_hit;
    input [7:0] alm;
    input [7:0] wday;
    input [7:0] date;
    begin
      if (!alm[`RTCAM_ALM_EN]) begin
        daydate_hit = 1'b1;
      end else if (alm[`RTCAM_ALM_DAYSEL]) begin
        daydate_hit = (alm[5:0] == wday[5:0]);
      end else begin
        daydate_hit = (alm[5:0] == date[5:0]);
      end
    end
  endfunction

  // Address decode for a write strobe.
  // Every register write goes through this one compare.
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // A flag clears on a completed status read with autoclear on,
  // or on a status write that holds a zero in its flag bit.
  // Writing a one to a flag bit must never touch it.
  function flag_clear;
    input auto_hit;
    input wr;
    input bit_val;
    begin
      flag_clear = auto_hit || (wr && !bit_val);
    end
  endfunction

  // Per-field alarm 1 compare against the freshly updated time.
  // The hour compare carries the format rule; the others check the value only.
  assign a1_hit[0] = field_hit(alarm1_second_r, time_sec);
  assign a1_hit[1] = field_hit(alarm1_minute_r, time_min);
  assign a1_hit[2] = field_hit(alarm1_hour_r, time_hour);
  assign a1_hit[3] = field_hit(alarm1_date_r, time_date);
  assign a1_hit[4] = field_hit(alarm1_month_r, time_month);
  assign a1_hit[5] = field_hit(alarm1_weekday_r, weekday_count);

  // All enables off leaves every field hitting, so each tick fires.
  assign a1_match = &a1_hit;

  // Alarm 1 is looked at once per seconds update. The time inputs hold
  // the new value from one tick to the next; comparing between ticks would
  // raise the alarm again on every clock of a matching second.
  assign a1_set = first_alarm_global_on_r && sec_tick && a1_match;

  // Per-field alarm 2 compare; there is no seconds byte.
  assign a2_hit[0] = field_hit(alarm2_minute_r, time_min);
  assign a2_hit[1] = field_hit(alarm2_hour_r, time_hour);
  assign a2_hit[2] = daydate_hit(alarm2_day_or_date_r, weekday_count, time_date);

  // All enables off leaves a hit on every minute.
  assign a2_match = &a2_hit;

  // The seconds byte reads zero only in the tick that starts a minute.
  assign at_minute = (time_sec == `RTCAM_SECONDS_ZERO);

  // Alarm 2 is looked at only when the seconds reach zero. Without
  // this check an alarm 2 with every field disabled would fire on
  // each second of the minute instead of once per minute.
  assign a2_set = second_alarm_global_on_r && sec_tick &&
                  at_minute && a2_match;

  // A status write of zero clears a flag; a one leaves it alone.
  // Bit 7 of the same write stores the autoclear control.
  assign wr_status = wr_hit(reg_addr, `RTCAM_ADDR_STATUS, reg_wr);

  // Autoclear acts on a completed status read only when enabled.
  // The stop pulse comes only after a valid status read, so other
  // reads leave the flags alone.
  assign autoclear = flag_autoclear_on_read_r && sr_read_stop;

  // Clear requests for each flag. The set request wins inside the flag
  // module, so a match in the clearing cycle is never lost.
  assign clr1 = flag_clear(autoclear, wr_status, reg_wdata[`RTCAM_SR_FLAG1]);
  assign clr2 = flag_clear(autoclear, wr_status, reg_wdata[`RTCAM_SR_FLAG2]);

  // Alarm 1 flag.
  // It feeds the status byte and the pin, which follows one clock later.
  rtcam_flag u_flag1 (
    .clk    (clk),
    .rst    (rst),
    .set    (a1_set),
    .clr    (clr1),
    .flag_r (first_alarm_flag)
  );

  // Alarm 2 flag.
  // It reaches only the status byte.
  rtcam_flag u_flag2 (
    .clk    (clk),
    .rst    (rst),
    .set    (a2_set),
    .clr    (clr2),
    .flag_r (second_alarm_flag)
  );

  // Alarm 1 register writes.
  // Each byte is stored whole with its enable in bit 7, so a read
  // returns exactly what was written.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm1_second_r  <= `RTCAM_RST_ALARM;
      alarm1_minute_r  <= `RTCAM_RST_ALARM;
      alarm1_hour_r    <= `RTCAM_RST_ALARM;
      alarm1_date_r    <= `RTCAM_RST_ALARM;
      alarm1_month_r   <= `RTCAM_RST_ALARM;
      alarm1_weekday_r <= `RTCAM_RST_ALARM;
    end else begin
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_SECOND, reg_wr)) begin
        alarm1_second_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_MINUTE, reg_wr)) begin
        alarm1_minute_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_HOUR, reg_wr)) begin
        alarm1_hour_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_DATE, reg_wr)) begin
        alarm1_date_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_MONTH, reg_wr)) begin
        alarm1_month_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A1_WEEKDAY, reg_wr)) begin
        alarm1_weekday_r <= reg_wdata;
      end
    end
  end

  // Alarm 2 register writes.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm2_minute_r      <= `RTCAM_RST_ALARM;
      alarm2_hour_r        <= `RTCAM_RST_ALARM;
      alarm2_day_or_date_r <= `RTCAM_RST_ALARM;
    end else begin
      if (wr_hit(reg_addr, `RTCAM_ADDR_A2_MINUTE, reg_wr)) begin
        alarm2_minute_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A2_HOUR, reg_wr)) begin
        alarm2_hour_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_A2_DAYDATE, reg_wr)) begin
        alarm2_day_or_date_r <= reg_wdata;
      end
    end
  end

  // Status and interrupt control writes.
  // Control bits 7 and 1 have no storage and read back as zero.
  // The flag bits of the status byte are handled by the clear logic.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_autoclear_on_read_r <= 1'b0;
      first_alarm_global_on_r  <= 1'b0;
      second_alarm_global_on_r <= 1'b0;
      pin_irq_select_r         <= 1'b0;
      first_alarm_pin_route_r  <= 1'b0;
      fo_sel_r                 <= `RTCAM_RST_FOSEL;
    end else begin
      if (wr_status) begin
        flag_autoclear_on_read_r <= reg_wdata[`RTCAM_SR_AUTOCLR];
      end
      if (wr_hit(reg_addr, `RTCAM_ADDR_INTCTL, reg_wr)) begin
        first_alarm_global_on_r  <= reg_wdata[`RTCAM_INT_ALM1ON];
        second_alarm_global_on_r <= reg_wdata[`RTCAM_INT_ALM2ON];
        fo_sel_r                 <= reg_wdata[`RTCAM_INT_FO_HI:`RTCAM_INT_FO_LO];
        pin_irq_select_r         <= reg_wdata[`RTCAM_INT_IRQSEL];
        first_alarm_pin_route_r  <= reg_wdata[`RTCAM_INT_ROUTE];
      end
    end
  end

  // Read data mux; unmapped and unused bits read as zero.
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `RTCAM_ADDR_STATUS: begin
        rdata_nxt[`RTCAM_SR_AUTOCLR] = flag_autoclear_on_read_r;
        rdata_nxt[`RTCAM_SR_FLAG1]   = first_alarm_flag;
        rdata_nxt[`RTCAM_SR_FLAG2]   = second_alarm_flag;
      end
      `RTCAM_ADDR_INTCTL: begin
        rdata_nxt[`RTCAM_INT_ALM1ON] = first_alarm_global_on_r;
        rdata_nxt[`RTCAM_INT_ALM2ON] = second_alarm_global_on_r;
        rdata_nxt[`RTCAM_INT_FO_HI:`RTCAM_INT_FO_LO] = fo_sel_r;
        rdata_nxt[`RTCAM_INT_IRQSEL] = pin_irq_select_r;
        rdata_nxt[`RTCAM_INT_ROUTE]  = first_alarm_pin_route_r;
      end
      `RTCAM_ADDR_A1_SECOND:  rdata_nxt = alarm1_second_r;
      `RTCAM_ADDR_A1_MINUTE:  rdata_nxt = alarm1_minute_r;
      `RTCAM_ADDR_A1_HOUR:    rdata_nxt = alarm1_hour_r;
      `RTCAM_ADDR_A1_DATE:    rdata_nxt = alarm1_date_r;
      `RTCAM_ADDR_A1_MONTH:   rdata_nxt = alarm1_month_r;
      `RTCAM_ADDR_A1_WEEKDAY: rdata_nxt = alarm1_weekday_r;
      `RTCAM_ADDR_A2_MINUTE:  rdata_nxt = alarm2_minute_r;
      `RTCAM_ADDR_A2_HOUR:    rdata_nxt = alarm2_hour_r;
      `RTCAM_ADDR_A2_DAYDATE: rdata_nxt = alarm2_day_or_date_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and then held.
  // The serial slave shifts the byte out over many clocks, so the
  // data must not follow later changes of the address.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // Interrupt mode needs the route and select bits together; frequency mode follows the select bit alone.
  // The frequency itself is divided outside; this block only enables it.
  assign pin_irq_mode  = first_alarm_pin_route_r && pin_irq_select_r;
  assign pin_freq_mode = !pin_irq_select_r;

  // The pin is open drain: it only ever pulls low, and only for
  // alarm 1, so a second alarm flag has no path to it.
  // With route low and select high the pin floats: the drive stays
  // released and the frequency output is off. The pull-down lags the
  // flag by one clock because it comes from this output register.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pin_o_r    <= 1'b0;
      irq_pin_oe_n_r <= 1'b1;
      fout_en_r      <= 1'b1;
      fout_sel_r     <= `RTCAM_RST_FOSEL;
    end else begin
      irq_pin_o_r    <= 1'b0;
      irq_pin_oe_n_r <= !(pin_irq_mode && first_alarm_flag);
      fout_en_r      <= pin_freq_mode;
      fout_sel_r     <= fo_sel_r;
    end
  end

  // One-cycle event pulses mark each raised alarm.
  // They show every new match even while the sticky flag is
  // already set, which the flag alone cannot do.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      first_alarm_event_r  <= 1'b0;
      second_alarm_event_r <= 1'b0;
    end else begin
      first_alarm_event_r  <= a1_set;
      second_alarm_event_r <= a2_set;
    end
  end

endmodule

// ===== hw/rtcam_defines.vh
// Register map, field positions and reset values of the dual alarm block.
// Operation
// - Alarm-1 bytes mirror time bytes, MSB enables.
// - All alarm-1 enables off: event every second.
// - Alarm-1 fires when all enabled fields match.
// - Any combination of six alarm-1 enables accepted.
// - Alarm-1 flag cleared by zero write, autoclear.
// - Alarm-1 match sets flag, pulls pin low.
// - Alarm-1 compared on each new seconds value.
// - Alarm-2 has minute, hour, day-or-date bytes only.
// - All alarm-2 enables off: event every minute.
// - Day-or-date selector picks weekday or date.
// - Alarm-2 flag set when enabled fields match.
// - Alarm-2 flag cleared by zero write, autoclear.
// - Alarm-2 compared on each new minutes value.
// - Autoclear clears both flags after status read.
// - Hour match needs identical 12/24 format bit.
// - Alarm 2 never drives the interrupt pin.
// - Pin is interrupt only with route and select.
`ifndef RTCAM_DEFINES_VH
`define RTCAM_DEFINES_VH

// Register addresses.
`define RTCAM_ADDR_STATUS     8'h07
`define RTCAM_ADDR_INTCTL     8'h08
`define RTCAM_ADDR_A1_SECOND  8'h0c
`define RTCAM_ADDR_A1_MINUTE  8'h0d
`define RTCAM_ADDR_A1_HOUR    8'h0e
`define RTCAM_ADDR_A1_DATE    8'h0f
`define RTCAM_ADDR_A1_MONTH   8'h10
`define RTCAM_ADDR_A1_WEEKDAY 8'h11
`define RTCAM_ADDR_A2_MINUTE  8'h12
`define RTCAM_ADDR_A2_HOUR    8'h13
`define RTCAM_ADDR_A2_DAYDATE 8'h14

// Status register bit positions.
`define RTCAM_SR_AUTOCLR 7
`define RTCAM_SR_FLAG1   2
`define RTCAM_SR_FLAG2   1

// Interrupt control register bit positions.
`define RTCAM_INT_ALM1ON 6
`define RTCAM_INT_ALM2ON 5
`define RTCAM_INT_FO_HI  4
`define RTCAM_INT_FO_LO  3
`define RTCAM_INT_IRQSEL 2
`define RTCAM_INT_ROUTE  0

// Alarm byte fields.
`define RTCAM_ALM_EN      7
`define RTCAM_ALM_DAYSEL  6
`define RTCAM_HOUR_FMT    6

// Reset values and the seconds value that starts a minute.
`define RTCAM_RST_ALARM   8'h00
`define RTCAM_RST_FOSEL   2'h3
`define RTCAM_SECONDS_ZERO 8'h00

`endif

// ===== hw/rtcam_flag.v
// Sticky alarm flag with set priority over clear.
`timescale 1ns/1ns
module rtcam_flag (
  // Clock and reset.
  input  wire clk,
  input  wire rst,
  // Set and clear requests.
  input  wire set,
  input  wire clr,
  // Flag state.
  output reg  flag_r
);

  reg flag_nxt;

  // A match in the clearing cycle keeps the flag set.
  always @* begin
    flag_nxt = flag_r;
    if (set) begin
      flag_nxt = 1'b1;
    end else if (clr) begin
      flag_nxt = 1'b0;
    end
  end

  // The flag holds its value between events.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// ===== tb/rtcam_monitor.sv
// Assertion checker for the dual alarm compare block.
`timescale 1ns/1ns
module rtcam_monitor (
  // Clock and reset.
  input wire       clk,
  input wire       rst,
  // Register and time inputs.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       sr_read_stop,
  input wire       sec_tick,
  input wire [7:0] time_sec,
  // Outputs under watch.
  input wire       irq_pin_oe_n_r,
  input wire       first_alarm_flag,
  input wire       second_alarm_flag,
  input wire       first_alarm_event_r,
  input wire       second_alarm_event_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A status write is the only host action that clears a flag by hand.
  sequence sr_wr_s;
    reg_wr && reg_addr == 8'h07;
  endsequence
  sequence clr1_s;
    sr_wr_s ##0 !reg_wdata[2] && !sec_tick;
  endsequence
  flag1_clear_a: assert property (clr1_s |=> !first_alarm_flag)
    else $error("alarm 1 flag not cleared by write");
  flag2_clear_a: assert property (sr_wr_s ##0 !reg_wdata[1] && !sec_tick |=> !second_alarm_flag)
    else $error("alarm 2 flag not cleared by write");
  flag1_hold_a: assert property (first_alarm_flag && !reg_wr && !sr_read_stop |=> first_alarm_flag)
    else $error("alarm 1 flag dropped");
  flag2_hold_a: assert property (second_alarm_flag && !reg_wr && !sr_read_stop |=> second_alarm_flag)
    else $error("alarm 2 flag dropped");
  event1_tick_a: assert property (first_alarm_event_r |-> first_alarm_flag && $past(sec_tick))
    else $error("alarm 1 event without update");
  event2_minute_a: assert property (second_alarm_event_r |-> $past(sec_tick) && $past(time_sec) == 8'h00)
    else $error("alarm 2 event off the minute");
  rise1_event_a: assert property ($rose(first_alarm_flag) |-> first_alarm_event_r)
    else $error("alarm 1 flag rose without event");
  pin_cause_a: assert property (!irq_pin_oe_n_r |-> $past(first_alarm_flag))
    else $error("pin pulled low without alarm 1 flag");
  pin_release_a: assert property ($fell(first_alarm_flag) |=> irq_pin_oe_n_r)
    else $error("pin not released after flag clear");
endmodule

bind rtcam_top rtcam_monitor i_rtcam_monitor (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .sr_read_stop,
  .sec_tick, .time_sec, .irq_pin_oe_n_r, .first_alarm_flag, .second_alarm_flag, .first_alarm_event_r,
  .second_alarm_event_r);

// ===== tb/rtcam_host.sv
// Host model that reaches the alarm block through its register port.
`timescale 1ns/1ns
module rtcam_host (
  // Clock.
  input  wire       clk,
  // Register port toward the block.
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg        sr_read_stop,
  input  wire [7:0] reg_rdata_r
);
  // Idle levels at time zero.
  initial begin
    reg_addr = 8'hff;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sr_read_stop = 1'b0;
  end
  // One byte write; a zero in a flag bit clears it, and address and data are inverted once released.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  // One byte read; data is taken after the edge that sampled the strobe.
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata_r;
      reg_addr = ~a;
    end
  endtask
  // Marks a finished status read closed by a stop condition.
  task stop;
    begin
      @(negedge clk);
      sr_read_stop = 1'b1;
      @(negedge clk);
      sr_read_stop = 1'b0;
    end
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking testbench for the dual alarm compare block.
`timescale 1ns/1ns
module testbench;
  localparam [47:0] MV = 48'h00_30_11_21_09_03;
  localparam [47:0] MS = 48'h59_29_12_20_08_02;
  reg        clk;
  reg        rst;
  reg        sec_tick;
  reg  [7:0] tm [0:5];
  wire [7:0] reg_addr, reg_wdata, reg_rdata_r;
  wire [1:0] fout_sel_r;
  wire       reg_wr, reg_rd, sr_read_stop, irq_pin_o_r, irq_pin_oe_n_r, fout_en_r;
  wire       first_alarm_flag, second_alarm_flag, first_alarm_event_r, second_alarm_event_r;
  wire [7:0] flags = {6'h00, first_alarm_flag, second_alarm_flag};
  wire [7:0] pins  = {3'h0, fout_sel_r, fout_en_r, irq_pin_o_r, irq_pin_oe_n_r};
  integer    fail_count;
  integer    n_checks;
  integer    i;
  rtcam_top i_rtcam_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .sr_read_stop, .reg_rdata_r,
    .sec_tick, .time_sec(tm[0]), .time_min(tm[1]), .time_hour(tm[2]), .time_date(tm[3]), .time_month(tm[4]),
    .weekday_count(tm[5]), .irq_pin_o_r, .irq_pin_oe_n_r, .fout_en_r, .fout_sel_r, .first_alarm_flag,
    .second_alarm_flag, .first_alarm_event_r, .second_alarm_event_r);
  rtcam_host i_rtcam_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .sr_read_stop, .reg_rdata_r);
  // Free-running clock at 4 ns.
  always #2 clk = ~clk;
  // Compares one byte of result.
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Reads one register and compares it.
  task chk_rd(input [7:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      i_rtcam_host.rd(a, v);
      chk("register", exp, v);
    end
  endtask
  // One seconds update with the present time; the new flags show on return.
  task tick;
    begin
      @(negedge clk);
      sec_tick = 1'b1;
      @(negedge clk);
      sec_tick = 1'b0;
    end
  endtask
  // Reset values, refused addresses and pin modes.
  task t_reset;
    begin
      chk("pins", 8'h1d, pins);
      chk_rd(8'h08, 8'h18);
      chk_rd(8'h07, 8'h00);
      chk_rd(8'h0d, 8'h00);
      i_rtcam_host.wr(8'h20, 8'hff);
      chk_rd(8'h20, 8'h00);
      i_rtcam_host.wr(8'h08, 8'hff);
      chk_rd(8'h08, 8'h7d);
      chk("pins", 8'h19, pins);
      i_rtcam_host.wr(8'h08, 8'h00);
      @(negedge clk);
      chk("pins", 8'h05, pins);
    end
  endtask
  // Alarm 1 with no field enabled, cleared by write, then globally off.
  task t_every_sec;
    begin
      i_rtcam_host.wr(8'h08, 8'h40);
      tick;
      chk("flags", 8'h02, flags);
      i_rtcam_host.wr(8'h07, 8'h00);
      chk("flags", 8'h00, flags);
      i_rtcam_host.wr(8'h08, 8'h00);
      tick;
      chk("flags", 8'h00, flags);
    end
  endtask
  // Each alarm 1 field alone, then all six with an hour format mismatch.
  task t_match;
    begin
      i_rtcam_host.wr(8'h08, 8'h40);
      for (i = 0; i < 6; i = i + 1) begin
        i_rtcam_host.wr(8'h0c + i[7:0], 8'h80 | MV[8*(5-i)+:8]);
        tm[i] = MS[8*(5-i)+:8];
        tick;
        chk("flags", 8'h00, flags);
        tm[i] = MV[8*(5-i)+:8];
        tick;
        chk("flags", 8'h02, flags);
        i_rtcam_host.wr(8'h07, 8'h00);
        if (i < 5) i_rtcam_host.wr(8'h0c + i[7:0], 8'h00);
      end
      for (i = 0; i < 5; i = i + 1) i_rtcam_host.wr(8'h0c + i[7:0], 8'h80 | MV[8*(5-i)+:8]);
      tm[2] = 8'h51;
      tick;
      chk("flags", 8'h00, flags);
      tm[2] = 8'h11;
      tick;
      chk("flags", 8'h02, flags);
    end
  endtask
  // Pin drive, sticky flag, refused set by write, autoclear and routing.
  task t_pin;
    begin
      i_rtcam_host.wr(8'h08, 8'h45);
      tick;
      chk("flags", 8'h02, flags);
      @(negedge clk);
      chk("pins", 8'h00, pins);
      tick;
      i_rtcam_host.wr(8'h07, 8'h86);
      chk("flags", 8'h02, flags);
      i_rtcam_host.stop;
      chk("flags", 8'h00, flags);
      @(negedge clk);
      chk("pins", 8'h01, pins);
      i_rtcam_host.wr(8'h07, 8'h00);
      i_rtcam_host.wr(8'h08, 8'h44);
      tick;
      @(negedge clk);
      chk("pins", 8'h01, pins);
      i_rtcam_host.wr(8'h07, 8'h00);
    end
  endtask
  // Alarm 2 once a minute, selector, field match and clears.
  task t_alarm2;
    begin
      i_rtcam_host.wr(8'h08, 8'h25);
      tm[0] = 8'h59;
      tick;
      chk("flags", 8'h00, flags);
      tm[0] = 8'h00;
      tick;
      chk("flags", 8'h01, flags);
      @(negedge clk);
      chk("pins", 8'h01, pins);
      i_rtcam_host.stop;
      chk("flags", 8'h01, flags);
      i_rtcam_host.wr(8'h07, 8'h00);
      chk("flags", 8'h00, flags);
      i_rtcam_host.wr(8'h14, 8'hc3);
      tick;
      chk("flags", 8'h01, flags);
      i_rtcam_host.wr(8'h07, 8'h00);
      i_rtcam_host.wr(8'h14, 8'h83);
      tick;
      chk("flags", 8'h00, flags);
      i_rtcam_host.wr(8'h14, 8'ha1);
      i_rtcam_host.wr(8'h12, 8'hb0);
      i_rtcam_host.wr(8'h13, 8'h91);
      tm[1] = 8'h29;
      tick;
      chk("flags", 8'h00, flags);
      tm[1] = 8'h30;
      tick;
      chk("flags", 8'h01, flags);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Watchdog against a hang.
  initial begin
    #100000;
    fail_count = fail_count + 1;
    end_of_test;
  end
  // Main sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sec_tick = 1'b0;
    fail_count = 0;
    n_checks = 0;
    for (i = 0; i < 6; i = i + 1) tm[i] = MV[8*(5-i)+:8];
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_every_sec;
    t_match;
    t_pin;
    t_alarm2;
    end_of_test;
  end
endmodule
